/* File: strap_config_map.vh */
`ifndef STRAP_CONFIG_MAP_VH
`define STRAP_CONFIG_MAP_VH

// register indices on the serial access port
`define IDX_FAST_PATH_MODE        8'h00
`define IDX_SIDE_CHANNEL_MODE     8'h01
`define IDX_INPUT_RECEIVER_SETUP  8'h02
`define IDX_TERM_PULSE_AB         8'h03
`define IDX_TERM_PULSE_CD         8'h04
`define IDX_EQUALIZER_LEVEL_AB    8'h05
`define IDX_EQUALIZER_LEVEL_CD    8'h06
`define IDX_OUTPUT_DRIVER_SETUP   8'h07

// mode register fields (fast path and side channel share layout)
`define ENABLE_BIT                6
`define SOURCE_HI                 1
`define SOURCE_LO                 0
// receiver setup field
`define IN_TERM_BIT               0
// output driver fields
`define BOOST_HI                  3
`define BOOST_LO                  2
`define OUT_TERM_BIT              1
`define DRIVE_CURRENT_BIT         0

// writable bits; everything else reads as zero
`define MASK_MODE                 8'h43
`define MASK_RECEIVER             8'h01
`define MASK_FULL                 8'hFF
`define MASK_DRIVER               8'h0F

// constants forced while straps govern
`define BYTE_ZERO                 8'h00
`define FORCED_ON                 1'h1
`define PULSE_FORCED              8'h00

// strap vector layout
`define STRAP_W                   8
`define STRAP_LANE_EN             0
`define STRAP_SEL_HI              2
`define STRAP_SEL_LO              1
`define STRAP_EQ                  3
`define STRAP_BOOST_HI            5
`define STRAP_BOOST_LO            4
`define STRAP_OUT_TERM            6
`define STRAP_DRIVE               7
`define SYNC_RESET                8'h00

// mode states, one-hot
`define MODE_W                    2
`define MODE_STRAP                2'h1
`define MODE_SERIAL               2'h2

`endif

/* File: strap_config_loader.v */
// Contract
// - lane enable strap 0 turns high-speed lanes off (standby), 1 on
// - source select strap routes input group A/B/C/D by code 00..11
// - same source select code drives the side-channel switch source
// - strap mode holds side-channel switch enabled regardless of lanes
// - strap mode keeps input terminations always on
// - strap mode keeps termination pulsing off for all four sources
// - strap mode applies one equalization level to every input lane
// - equalization strap: 0 low 6 dB, 1 high 12 dB
// - boost straps: 00 none, 01 2 dB, 10 4 dB, 11 6 dB
// - output termination strap: 0 off, 1 on, all output lanes
// - drive current strap: 0 gives 10 mA, 1 gives 20 mA
// - serial access can enable or disable input and output terminations
// - straps govern from reset until first serial access, then registers
`timescale 1ns/10ps
`include "strap_config_map.vh"

module strap_config_loader
(
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire       clk_en,
  input  wire       lane_enable_strap,
  input  wire [1:0] source_select_strap,
  input  wire       eq_level_strap,
  input  wire [1:0] boost_level_strap,
  input  wire       out_term_strap,
  input  wire       drive_current_strap,
  input  wire       serial_wr_en,
  input  wire       serial_rd_en,
  input  wire [7:0] serial_addr,
  input  wire [7:0] serial_wdata,
  output reg  [7:0] serial_rdata,
  output reg        serial_rd_valid,
  output wire       strap_mode,
  output reg  [7:0] fast_path_mode,
  output reg  [7:0] side_channel_mode,
  output reg  [7:0] input_receiver_setup,
  output reg  [7:0] term_pulse_ab,
  output reg  [7:0] term_pulse_cd,
  output reg  [7:0] equalizer_level_ab,
  output reg  [7:0] equalizer_level_cd,
  output reg  [7:0] output_driver_setup,
  output wire       lanes_on,
  output wire [1:0] fast_source,
  output wire       side_channel_on,
  output wire [1:0] side_common_port_sel,
  output wire       input_term_on,
  output wire [1:0] output_boost,
  output wire       output_term_on,
  output wire       serial_drive_current_field
);

////////////////////////////////////////////////////////////////////////////
// strap synchroniser

  wire [`STRAP_W-1:0] strap_raw;
  reg  [`STRAP_W-1:0] strap_meta;
  reg  [`STRAP_W-1:0] strap_sync;

  // pins are static on the board, yet still crossed into clk_sys
  // price of the crossing: a pin change shows three enabled edges later,
  // where a clockless decode would follow at once
  assign strap_raw[`STRAP_LANE_EN] = lane_enable_strap;
  assign strap_raw[`STRAP_SEL_HI:`STRAP_SEL_LO] = source_select_strap;
  assign strap_raw[`STRAP_EQ] = eq_level_strap;
  assign strap_raw[`STRAP_BOOST_HI:`STRAP_BOOST_LO] = boost_level_strap;
  assign strap_raw[`STRAP_OUT_TERM] = out_term_strap;
  assign strap_raw[`STRAP_DRIVE] = drive_current_strap;

  // two flops per strap bit; only the second stage is read onward
  // a reset value of zero loads a lanes-off image until the pins arrive
  genvar gi;
  generate
    for (gi = 0; gi < `STRAP_W; gi = gi + 1)
    begin : g_sync
      always @(posedge clk_sys)
      begin
        if (!rst_b)
        begin
          strap_meta[gi] <= 1'h0;
          strap_sync[gi] <= 1'h0;
        end
        else if (clk_en)
        begin
          strap_meta[gi] <= strap_raw[gi];
          strap_sync[gi] <= strap_meta[gi];
        end
      end
    end
  endgenerate

////////////////////////////////////////////////////////////////////////////
// register images derived from the straps

  reg [7:0] strap_fast;
  reg [7:0] strap_side;
  reg [7:0] strap_rx;
  reg [7:0] strap_tx;
  wire [7:0] strap_eq;

  // one strap bit fans out to every lane of every source
  assign strap_eq = {8{strap_sync[`STRAP_EQ]}};

  // images rebuilt every cycle from the synchronised straps
  // side-channel enable and input termination are constants here: no
  // pin can turn them off
  always @*
  begin
    strap_fast = `BYTE_ZERO;
    strap_fast[`ENABLE_BIT] = strap_sync[`STRAP_LANE_EN];
    strap_fast[`SOURCE_HI:`SOURCE_LO] =
      strap_sync[`STRAP_SEL_HI:`STRAP_SEL_LO];
    strap_side = `BYTE_ZERO;
    strap_side[`ENABLE_BIT] = `FORCED_ON;
    strap_side[`SOURCE_HI:`SOURCE_LO] =
      strap_sync[`STRAP_SEL_HI:`STRAP_SEL_LO];
    strap_rx = `BYTE_ZERO;
    strap_rx[`IN_TERM_BIT] = `FORCED_ON;
    strap_tx = `BYTE_ZERO;
    strap_tx[`BOOST_HI:`BOOST_LO] =
      strap_sync[`STRAP_BOOST_HI:`STRAP_BOOST_LO];
    strap_tx[`OUT_TERM_BIT] = strap_sync[`STRAP_OUT_TERM];
    strap_tx[`DRIVE_CURRENT_BIT] = strap_sync[`STRAP_DRIVE];
  end

////////////////////////////////////////////////////////////////////////////
// source of control: straps or serial registers

  // one-hot codes; a corrupted code falls back to pin control
  localparam [`MODE_W-1:0] ST_STRAP  = `MODE_STRAP;
  localparam [`MODE_W-1:0] ST_SERIAL = `MODE_SERIAL;

  reg  [`MODE_W-1:0] mode;
  reg  [`MODE_W-1:0] next_mode;
  wire               serial_access;

  // a read counts as an access just as a write does
  // strobes seen while clk_en is low never reach the mode register
  assign serial_access = serial_wr_en | serial_rd_en;

  // straps hand over once and never take control back until reset
  // a board rework therefore needs a reset before it takes effect
  always @*
  begin
    next_mode = mode;
    case (mode)
      ST_STRAP:
      begin
        if (serial_access)
          next_mode = ST_SERIAL;
      end
      ST_SERIAL:
      begin
        next_mode = ST_SERIAL;
      end
      default:
      begin
        next_mode = ST_STRAP;
      end
    endcase
  end

  // mode register
  // frozen by clk_en like every other flop
  always @(posedge clk_sys)
  begin
    if (!rst_b)
      mode <= ST_STRAP;
    else if (clk_en)
      mode <= next_mode;
  end

  assign strap_mode = (mode == ST_STRAP);

////////////////////////////////////////////////////////////////////////////
// write decode

  reg       wr_fast;
  reg       wr_side;
  reg       wr_rx;
  reg       wr_pab;
  reg       wr_pcd;
  reg       wr_eab;
  reg       wr_ecd;
  reg       wr_tx;

  // unmapped indices raise no strobe, so such writes vanish
  // every index bit is compared, so no upper-bit alias hits a register;
  // the read path below decodes the same indices
  always @*
  begin
    wr_fast = 1'h0;
    wr_side = 1'h0;
    wr_rx   = 1'h0;
    wr_pab  = 1'h0;
    wr_pcd  = 1'h0;
    wr_eab  = 1'h0;
    wr_ecd  = 1'h0;
    wr_tx   = 1'h0;
    if (!serial_wr_en)
      wr_fast = 1'h0;
    else if (serial_addr == `IDX_FAST_PATH_MODE)
      wr_fast = 1'h1;
    else if (serial_addr == `IDX_SIDE_CHANNEL_MODE)
      wr_side = 1'h1;
    else if (serial_addr == `IDX_INPUT_RECEIVER_SETUP)
      wr_rx = 1'h1;
    else if (serial_addr == `IDX_TERM_PULSE_AB)
      wr_pab = 1'h1;
    else if (serial_addr == `IDX_TERM_PULSE_CD)
      wr_pcd = 1'h1;
    else if (serial_addr == `IDX_EQUALIZER_LEVEL_AB)
      wr_eab = 1'h1;
    else if (serial_addr == `IDX_EQUALIZER_LEVEL_CD)
      wr_ecd = 1'h1;
    else if (serial_addr == `IDX_OUTPUT_DRIVER_SETUP)
      wr_tx = 1'h1;
  end

////////////////////////////////////////////////////////////////////////////
// register file

  // in strap mode every register tracks the strap images; once serial
  // control starts the last image stays until software overwrites it,
  // and the first access itself may already write
  // reset clears every register; pin images arrive three edges later
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      fast_path_mode       <= `BYTE_ZERO;
      side_channel_mode    <= `BYTE_ZERO;
      input_receiver_setup <= `BYTE_ZERO;
      term_pulse_ab        <= `BYTE_ZERO;
      term_pulse_cd        <= `BYTE_ZERO;
      equalizer_level_ab   <= `BYTE_ZERO;
      equalizer_level_cd   <= `BYTE_ZERO;
      output_driver_setup  <= `BYTE_ZERO;
    end
    else if (clk_en)
    begin
      // the access edge is already serial, so a first write lands
      if (strap_mode && !serial_access)
      begin
        fast_path_mode       <= strap_fast;
        side_channel_mode    <= strap_side;
        input_receiver_setup <= strap_rx;
        term_pulse_ab        <= `PULSE_FORCED;
        term_pulse_cd        <= `PULSE_FORCED;
        equalizer_level_ab   <= strap_eq;
        equalizer_level_cd   <= strap_eq;
        output_driver_setup  <= strap_tx;
      end
      else
      begin
        if (wr_fast)
          fast_path_mode <= serial_wdata & `MASK_MODE;
        if (wr_side)
          side_channel_mode <= serial_wdata & `MASK_MODE;
        if (wr_rx)
          input_receiver_setup <= serial_wdata & `MASK_RECEIVER;
        if (wr_pab)
          term_pulse_ab <= serial_wdata & `MASK_FULL;
        if (wr_pcd)
          term_pulse_cd <= serial_wdata & `MASK_FULL;
        if (wr_eab)
          equalizer_level_ab <= serial_wdata & `MASK_FULL;
        if (wr_ecd)
          equalizer_level_cd <= serial_wdata & `MASK_FULL;
        if (wr_tx)
          output_driver_setup <= serial_wdata & `MASK_DRIVER;
      end
    end
  end

////////////////////////////////////////////////////////////////////////////
// read path

  reg [7:0] next_rdata;

  // register stage is read, so a strap-mode read returns the last image
  // a read in the same cycle as a write still returns the old value
  always @*
  begin
    next_rdata = `BYTE_ZERO;
    if (serial_addr == `IDX_FAST_PATH_MODE)
      next_rdata = fast_path_mode;
    else if (serial_addr == `IDX_SIDE_CHANNEL_MODE)
      next_rdata = side_channel_mode;
    else if (serial_addr == `IDX_INPUT_RECEIVER_SETUP)
      next_rdata = input_receiver_setup;
    else if (serial_addr == `IDX_TERM_PULSE_AB)
      next_rdata = term_pulse_ab;
    else if (serial_addr == `IDX_TERM_PULSE_CD)
      next_rdata = term_pulse_cd;
    else if (serial_addr == `IDX_EQUALIZER_LEVEL_AB)
      next_rdata = equalizer_level_ab;
    else if (serial_addr == `IDX_EQUALIZER_LEVEL_CD)
      next_rdata = equalizer_level_cd;
    else if (serial_addr == `IDX_OUTPUT_DRIVER_SETUP)
      next_rdata = output_driver_setup;
  end

  // read data held until the next read; valid is the read strobe delayed by one enabled edge
  // valid follows the strobe even for unmapped indices, which read zero
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      serial_rdata    <= `BYTE_ZERO;
      serial_rd_valid <= 1'h0;
    end
    else if (clk_en)
    begin
      serial_rd_valid <= serial_rd_en;
      if (serial_rd_en)
        serial_rdata <= next_rdata;
    end
  end

////////////////////////////////////////////////////////////////////////////
// decoded controls for the analog switch, equalizer and driver

  // slices of the registers, so they change only on a clock edge
  // they feed the analog switch, equalizer and driver directly, so a
  // glitch here would disturb the lanes
  assign lanes_on = fast_path_mode[`ENABLE_BIT];
  assign fast_source = fast_path_mode[`SOURCE_HI:`SOURCE_LO];
  assign side_channel_on = side_channel_mode[`ENABLE_BIT];
  assign side_common_port_sel =
    side_channel_mode[`SOURCE_HI:`SOURCE_LO];
  assign input_term_on = input_receiver_setup[`IN_TERM_BIT];
  assign output_boost =
    output_driver_setup[`BOOST_HI:`BOOST_LO];
  assign output_term_on =
    output_driver_setup[`OUT_TERM_BIT];
  assign serial_drive_current_field =
    output_driver_setup[`DRIVE_CURRENT_BIT];

endmodule

/* File: strap_config_chk.sv */
`timescale 1ns/10ps
module strap_config_chk
(
  input wire       clk_sys,
  input wire       rst_b,
  input wire       clk_en,
  input wire       lane_enable_strap,
  input wire [1:0] source_select_strap,
  input wire       eq_level_strap,
  input wire [1:0] boost_level_strap,
  input wire       out_term_strap,
  input wire       drive_current_strap,
  input wire       serial_wr_en,
  input wire       serial_rd_en,
  input wire       serial_rd_valid,
  input wire       strap_mode,
  input wire [7:0] fast_path_mode,
  input wire [7:0] side_channel_mode,
  input wire [7:0] input_receiver_setup,
  input wire [7:0] term_pulse_ab,
  input wire [7:0] term_pulse_cd,
  input wire [7:0] equalizer_level_ab,
  input wire [7:0] equalizer_level_cd,
  input wire [7:0] output_driver_setup
);
  wire [7:0] pins = {drive_current_strap, out_term_strap, boost_level_strap,
                     eq_level_strap, source_select_strap, lane_enable_strap};
  reg  [7:0] last_pins;
  reg  [2:0] quiet;
  wire       settled = strap_mode && (quiet > 3'h4) && (pins == last_pins);

  // counts stable enabled edges; images lag the pins through the synchroniser
  always @(posedge clk_sys)
  begin
    last_pins <= pins;
    if (!rst_b || !clk_en || pins != last_pins)
      quiet <= 3'h0;
    else if (quiet != 3'h7)
      quiet <= quiet + 3'h1;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  lane_image_a: assert property (settled |-> fast_path_mode ==
    {2'h1 & {1'h0, lane_enable_strap}, 4'h0, source_select_strap})
    else $error("fast path mode does not match pins");
  side_image_a: assert property (settled |-> side_channel_mode ==
    {2'h1, 4'h0, source_select_strap}) else $error("side mode wrong");
  in_term_a: assert property (settled |-> input_receiver_setup == 8'h01)
    else $error("input termination not forced on");
  pulse_off_a: assert property (settled |-> term_pulse_ab == 8'h00
    && term_pulse_cd == 8'h00) else $error("pulsing not forced off");
  eq_image_a: assert property (settled |-> equalizer_level_ab ==
    {8{eq_level_strap}} && equalizer_level_cd == {8{eq_level_strap}})
    else $error("equalizer image wrong");
  drive_image_a: assert property (settled |->
    output_driver_setup == {4'h0, boost_level_strap, out_term_strap,
    drive_current_strap}) else $error("driver image wrong");
  handover_now_a: assert property (
    clk_en && (serial_rd_en || serial_wr_en) |=> !strap_mode)
    else $error("access did not end pin mode");
  serial_stays_a: assert property (!strap_mode |=> !strap_mode)
    else $error("pin mode came back without reset");
  read_answer_a: assert property (clk_en && serial_rd_en |=>
    serial_rd_valid) else $error("read not answered");
endmodule

////////////////////////////////////////////////////////////////////////////
bind strap_config_loader strap_config_chk chk_u (.clk_sys(clk_sys),
  .rst_b(rst_b), .clk_en(clk_en), .lane_enable_strap(lane_enable_strap),
  .source_select_strap(source_select_strap), .eq_level_strap(eq_level_strap),
  .boost_level_strap(boost_level_strap), .out_term_strap(out_term_strap),
  .drive_current_strap(drive_current_strap), .serial_wr_en(serial_wr_en),
  .serial_rd_en(serial_rd_en), .serial_rd_valid(serial_rd_valid),
  .strap_mode(strap_mode), .fast_path_mode(fast_path_mode),
  .side_channel_mode(side_channel_mode),
  .input_receiver_setup(input_receiver_setup),
  .term_pulse_ab(term_pulse_ab), .term_pulse_cd(term_pulse_cd),
  .equalizer_level_ab(equalizer_level_ab),
  .equalizer_level_cd(equalizer_level_cd),
  .output_driver_setup(output_driver_setup));

/* File: board_strap_model.sv */
`timescale 1ns/10ps
module board_strap_model
(
  input  wire [7:0] strap_code,
  output wire       lane_enable_strap,
  output wire [1:0] source_select_strap,
  output wire       eq_level_strap,
  output wire [1:0] boost_level_strap,
  output wire       out_term_strap,
  output wire       drive_current_strap
);
  // hard ties to supply or ground; a new code stands for a board rework
  assign {drive_current_strap, out_term_strap, boost_level_strap,
          eq_level_strap, source_select_strap, lane_enable_strap}
         = strap_code;
endmodule

/* File: switch_pin_strap_config_bench.sv */
`timescale 1ns/10ps
`include "strap_config_map.vh"
module switch_pin_strap_config_bench;
  reg        clk_sys, rst_b, clk_en, serial_wr_en, serial_rd_en;
  reg  [7:0] serial_addr, serial_wdata, code;
  wire       lane_enable_strap, eq_level_strap, out_term_strap;
  wire       drive_current_strap, serial_rd_valid, strap_mode;
  wire [1:0] source_select_strap, boost_level_strap;
  wire [7:0] serial_rdata, fast_path_mode, side_channel_mode;
  wire [7:0] input_receiver_setup, term_pulse_ab, term_pulse_cd;
  wire [7:0] equalizer_level_ab, equalizer_level_cd, output_driver_setup;
  wire       lanes_on, side_channel_on, input_term_on, output_term_on;
  wire       serial_drive_current_field;
  wire [1:0] fast_source, side_common_port_sel, output_boost;
  integer    mismatches, n_tests, i;
  wire [63:0] regs_all = {fast_path_mode, side_channel_mode,
    input_receiver_setup, term_pulse_ab, term_pulse_cd,
    equalizer_level_ab, equalizer_level_cd, output_driver_setup};
  wire [10:0] slices = {lanes_on, fast_source, side_channel_on,
    side_common_port_sel, input_term_on, output_boost, output_term_on,
    serial_drive_current_field};

  board_strap_model board_u (.strap_code(code),
    .lane_enable_strap(lane_enable_strap),
    .source_select_strap(source_select_strap),
    .eq_level_strap(eq_level_strap), .boost_level_strap(boost_level_strap),
    .out_term_strap(out_term_strap),
    .drive_current_strap(drive_current_strap));

  strap_config_loader dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
    .clk_en(clk_en), .lane_enable_strap(lane_enable_strap),
    .source_select_strap(source_select_strap),
    .eq_level_strap(eq_level_strap), .boost_level_strap(boost_level_strap),
    .out_term_strap(out_term_strap),
    .drive_current_strap(drive_current_strap),
    .serial_wr_en(serial_wr_en), .serial_rd_en(serial_rd_en),
    .serial_addr(serial_addr), .serial_wdata(serial_wdata),
    .serial_rdata(serial_rdata), .serial_rd_valid(serial_rd_valid),
    .strap_mode(strap_mode), .fast_path_mode(fast_path_mode),
    .side_channel_mode(side_channel_mode),
    .input_receiver_setup(input_receiver_setup),
    .term_pulse_ab(term_pulse_ab), .term_pulse_cd(term_pulse_cd),
    .equalizer_level_ab(equalizer_level_ab),
    .equalizer_level_cd(equalizer_level_cd),
    .output_driver_setup(output_driver_setup), .lanes_on(lanes_on),
    .fast_source(fast_source), .side_channel_on(side_channel_on),
    .side_common_port_sel(side_common_port_sel),
    .input_term_on(input_term_on), .output_boost(output_boost),
    .output_term_on(output_term_on),
    .serial_drive_current_field(serial_drive_current_field));

  ////////////////////////////////////////////////////////////////////////////
  // register image that a pin code must produce
  function [63:0] img(input [7:0] c);
    img = {2'h1 & {1'h0, c[0]}, 4'h0, c[2:1], 2'h1, 4'h0, c[2:1], 8'h01,
           16'h0000, {16{c[3]}}, 4'h0, c[5:4], c[6], c[7]};
  endfunction

  // writable bits per index; unmapped places read as zero
  function [7:0] mask(input [7:0] a);
    case (a)
      8'h00, 8'h01: mask = `MASK_MODE;
      8'h02:        mask = `MASK_RECEIVER;
      8'h07:        mask = `MASK_DRIVER;
      8'h03, 8'h04, 8'h05, 8'h06: mask = `MASK_FULL;
      default:      mask = 8'h00;
    endcase
  endfunction

  task chk(input [63:0] got, input [63:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // strobes rise and fall on falling edges, one rising edge apart
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      serial_wr_en = 1'h1;
      serial_addr = a;
      serial_wdata = d;
      @(negedge clk_sys);
      serial_wr_en = 1'h0;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      serial_rd_en = 1'h1;
      serial_addr = a;
      @(negedge clk_sys);
      serial_rd_en = 1'h0;
      chk(serial_rd_valid, 1'h1);
      chk(serial_rdata, e);
    end
  endtask

  task conclude;
    begin
      if (mismatches == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial
  begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // a hang counts as a mismatch; the whole run needs under 600 cycles
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    mismatches = mismatches + 1;
    conclude;
  end

  initial
  begin
    mismatches = 0;
    n_tests = 0;
    rst_b = 1'h0;
    clk_en = 1'h1;
    serial_wr_en = 1'h0;
    serial_rd_en = 1'h0;
    serial_addr = 8'h00;
    serial_wdata = 8'h00;
    code = 8'h00;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'h1;
    chk(strap_mode, 1'h1);
    // every select and boost code, each single pin both ways
    for (i = 0; i < 16; i = i + 1)
    begin
      code = {i[3:0], ~i[3:0]};
      repeat (6) @(negedge clk_sys);
      chk(regs_all, img(code));
      chk(slices, {code[0], code[2:1], 1'h1, code[2:1], 1'h1,
                   code[5:4], code[6], code[7]});
    end
    // a strobe while frozen is no access
    clk_en = 1'h0;
    wr(8'h00, 8'h00);
    clk_en = 1'h1;
    chk(strap_mode, 1'h1);
    chk(regs_all, img(code));
    rd(`IDX_FAST_PATH_MODE, img(code) >> 56);
    chk(strap_mode, 1'h0);
    code = ~code;
    repeat (6) @(negedge clk_sys);
    chk(regs_all, img(~code));
    for (i = 0; i < 9; i = i + 1)
      wr(i[7:0], 8'hFF);
    for (i = 0; i < 9; i = i + 1)
      rd(i[7:0], mask(i[7:0]));
    wr(`IDX_INPUT_RECEIVER_SETUP, 8'h00);
    wr(`IDX_OUTPUT_DRIVER_SETUP, 8'h00);
    @(negedge clk_sys);
    chk(slices, {1'h1, 2'h3, 1'h1, 2'h3, 5'h00});
    // a second reset hands control back to the pins
    rst_b = 1'h0;
    repeat (2) @(negedge clk_sys);
    rst_b = 1'h1;
    chk(strap_mode, 1'h1);
    repeat (6) @(negedge clk_sys);
    chk(regs_all, img(code));
    conclude;
  end
endmodule
